/* shared/scp_pkg.sv */
// Constants, register map and carrier types for the safety and pin control logic.
package scp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 125;
  localparam int SYNC_LEAD_US   = 20;
  localparam int DEBOUNCE_US    = 20;
  localparam int WDOG_REL_US    = 30;
  localparam int SYNC_LEAD_CYC  = SYNC_LEAD_US * CLK_MHZ;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int WDOG_REL_CYC   = WDOG_REL_US * CLK_MHZ;
  localparam int CNT_W          = 12;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_FLAGS  = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_BUSID  = 4'h3;

  localparam int CTRL_PIN_SEL  = 0;
  localparam int CTRL_RUN_EN   = 1;
  localparam int CTRL_STBY_EN  = 2;
  localparam int CTRL_SOFT_SEL = 3;
  localparam int CTRL_WDI_SEL  = 4;
  localparam int CTRL_WDC_SEL  = 5;
  localparam int CTRL_HARD_SEL = 6;

  localparam int FLAG_SAFE = 0;
  localparam int FLAG_WDI  = 1;
  localparam int FLAG_SOFT = 2;
  localparam int FLAG_WDC  = 3;
  localparam int FLAG_HARD = 4;

  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [6:0] CFG_MODE_BUS_ADDR = 7'h08;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    FS_OFF, FS_RELEASED, FS_PRE_DOWN, FS_DOWN, FS_WDOG_HOLD
  } scp_fs_e;

  typedef struct packed {
    logic run_state;
    logic standby_state;
    logic off_mode;
    logic system_on;
    logic power_on_request;
    logic ready_to_sequence;
    logic outputs_off;
    logic fuses_loaded;
    logic power_up_event;
  } scp_sys_s;

  typedef struct packed {
    logic self_test_fail;
    logic regulator_fault;
    logic soft_fault_evt;
    logic wdog_input_evt;
    logic soft_wdog_reset;
    logic wdog_counter_reset;
    logic hard_wdog_reset;
    logic fault_timer_expired;
    logic fault_count_limit;
    logic wdog_count_limit;
    logic power_up_failure;
    logic thermal_shutdown;
    logic input_undervoltage_detect;
  } scp_evt_s;

  typedef struct packed {
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic [7:0]       ctrl;
    logic [4:0]       flags;
    logic             safe_state;
    logic             safety_drive;
    logic             reg2_enable;
    scp_fs_e          fs;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] deb;
    logic             wdog_down;
    logic             fail_drive;
    logic             down_start;
    logic             fuse_reload;
    logic [7:0]       rdata;
    logic [6:0]       bus_addr;
  } scp_state_s;

endpackage : scp_pkg

/* design/scp_pin_ctrl.sv */
// Regulator enable pin, safety output, configuration strap and fail-sync pin control.
`timescale 1ns/100ps
// Notes on behaviour
// - Select 0: regulator follows state enable; select 1: also needs enable pin high.
// - Run state uses run enable bit, standby state uses standby enable bit.
// - Read-only status bit mirrors the regulator enable pin level.
// - Fused bit picks active safe mode, else fault safe mode; no fuse means fault mode.
// - Active mode drives safety output low after fuse load while in safe state.
// - Active mode enters safe state on self-test, selected flags, hard reset, off reset, flag.
// - Every safe state entry drives output low and sets the safe state flag.
// - Safe state exits only with reset released, self-test clean, no faults, selected flags and safe flag clear.
// - Fault mode keeps output released unless an enabled fault selection asserts it.
// - Soft fault select latches regulator OV, UV or current limit faults onto output.
// - Watchdog input select latches watchdog input and soft resets onto output.
// - Watchdog counter select latches counter started watchdog resets onto output.
// - Hard fault select latches timer, counter, power up and thermal faults onto output.
// - Fault mode releases output once flags clear or input undervoltage is detected.
// - Strap high forces serial bus address 0x08.
// - Strap high disables watchdogs, and CRC and secure writes without power up event.
// - Fused fail-sync enable low makes the device ignore the fail-sync pin.
// - Internal hard shutdown pulls fail-sync low 20 us before power down starts.
// - Fail-sync pin is held low in all off modes.
// - External fail-sync low beyond 20 us debounce starts power down and is driven low.
// - Power on releases fail-sync and pauses power up while it is held low externally.
// - After hard watchdog power down, release pin after 30 us and reload fuse defaults.
module scp_pin_ctrl #(
  parameter bit HAS_SAFE_FUSE = 1'b1
) (
  input  wire logic            CLK,
  input  wire logic            SYS_RST,
  input  wire logic [3:0]      ADDR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output logic      [7:0]      RDATA,
  input  wire scp_pkg::scp_sys_s SYS,
  input  wire scp_pkg::scp_evt_s EVT,
  input  wire logic            HOST_RESET_N,
  input  wire logic            FUSED_ACTIVE_SAFE_ENABLE,
  input  wire logic            FUSED_SYNC_FAIL_ENABLE,
  input  wire logic            FUSED_PIN_CONTROL_DEFAULT,
  input  wire logic [6:0]      FUSED_BUS_ADDR,
  input  wire logic            REGULATOR_TWO_ENABLE_PIN,
  input  wire logic            CONFIG_MODE_STRAP,
  input  wire logic            SYNC_FAIL_N_I,
  output logic                 SYNC_FAIL_N_O,
  output logic                 SYNC_FAIL_N_OE,
  output logic                 SAFETY_OUT_N_O,
  output logic                 SAFETY_OUT_N_OE,
  output logic                 REGULATOR_TWO_ENABLE,
  output logic [6:0]           BUS_ADDR,
  output logic                 WDOG_DISABLE,
  output logic                 CRC_SECURE_DISABLE,
  output logic                 POWER_UP_PAUSE,
  output logic                 POWER_DOWN_START,
  output logic                 FUSE_RELOAD
);

  // ****************************************************************
  // State
  // ****************************************************************
  scp_pkg::scp_state_s st_ff;
  scp_pkg::scp_state_s nxt_st;
  typedef logic [scp_pkg::CNT_W-1:0] scp_cnt_t;

  logic       en_pin_s;
  logic       strap_s;
  logic       fail_pin_s;
  logic       active_mode;
  logic       fs_en;
  logic       hard_shutdown;
  logic       state_term;
  logic       safe_entry;
  logic       safe_exit_ok;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  // Only the second stage is read; the first feeds it alone.
  assign en_pin_s   = st_ff.sync2[0];
  assign strap_s    = st_ff.sync2[1];
  assign fail_pin_s = st_ff.sync2[2];

  assign active_mode = HAS_SAFE_FUSE && FUSED_ACTIVE_SAFE_ENABLE;
  assign fs_en       = FUSED_SYNC_FAIL_ENABLE;

  assign hard_shutdown = EVT.fault_timer_expired | EVT.fault_count_limit | EVT.wdog_count_limit
                       | EVT.power_up_failure | EVT.thermal_shutdown;

  // ****************************************************************
  // Combinational next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.down_start  = 1'b0;
    nxt_st.fuse_reload = 1'b0;
    nxt_st.rdata       = 8'h00;

    nxt_st.sync1 = {SYNC_FAIL_N_I, CONFIG_MODE_STRAP, REGULATOR_TWO_ENABLE_PIN};
    nxt_st.sync2 = st_ff.sync1;

    // Register writes.
    if (WR && ADDR == scp_pkg::ADDR_CTRL) begin
      nxt_st.ctrl = {1'b0, WDATA[6:0]};
    end
    // The pin control default comes from the fuses once they are loaded.
    if (SYS.fuses_loaded) begin
      nxt_st.ctrl[scp_pkg::CTRL_PIN_SEL] = FUSED_PIN_CONTROL_DEFAULT;
    end

    // Regulator two enable.
    if (SYS.run_state) begin
      state_term = st_ff.ctrl[scp_pkg::CTRL_RUN_EN];
    end else if (SYS.standby_state) begin
      state_term = st_ff.ctrl[scp_pkg::CTRL_STBY_EN];
    end else begin
      state_term = 1'b0;
    end
    nxt_st.reg2_enable = state_term && (!st_ff.ctrl[scp_pkg::CTRL_PIN_SEL] || en_pin_s);

    // Fault flag sources.
    flag_set = 5'h00;
    flag_set[scp_pkg::FLAG_SOFT] = st_ff.ctrl[scp_pkg::CTRL_SOFT_SEL] && EVT.soft_fault_evt;
    flag_set[scp_pkg::FLAG_WDI]  = st_ff.ctrl[scp_pkg::CTRL_WDI_SEL]
                                 && (EVT.wdog_input_evt || EVT.soft_wdog_reset);
    flag_set[scp_pkg::FLAG_WDC]  = st_ff.ctrl[scp_pkg::CTRL_WDC_SEL] && EVT.wdog_counter_reset;
    flag_set[scp_pkg::FLAG_HARD] = st_ff.ctrl[scp_pkg::CTRL_HARD_SEL] && hard_shutdown;

    // Active safe state tracking.
    safe_entry = EVT.self_test_fail
               || (st_ff.ctrl[scp_pkg::CTRL_WDI_SEL] && st_ff.flags[scp_pkg::FLAG_WDI])
               || (st_ff.ctrl[scp_pkg::CTRL_SOFT_SEL] && st_ff.flags[scp_pkg::FLAG_SOFT])
               || EVT.hard_wdog_reset
               || (SYS.off_mode && !HOST_RESET_N)
               || st_ff.flags[scp_pkg::FLAG_SAFE]
               || SYS.fuses_loaded;
    safe_exit_ok = HOST_RESET_N && !EVT.self_test_fail && !EVT.regulator_fault
                 && !(st_ff.ctrl[scp_pkg::CTRL_WDI_SEL] && st_ff.flags[scp_pkg::FLAG_WDI])
                 && !(st_ff.ctrl[scp_pkg::CTRL_SOFT_SEL] && st_ff.flags[scp_pkg::FLAG_SOFT]);
    if (active_mode) begin
      if (safe_entry) begin
        nxt_st.safe_state = 1'b1;
        // Entry from the released state raises the flag so the host must confirm.
        if (!st_ff.safe_state) begin
          flag_set[scp_pkg::FLAG_SAFE] = 1'b1;
        end
      end else if (safe_exit_ok) begin
        nxt_st.safe_state = 1'b0;
      end
    end else begin
      nxt_st.safe_state = 1'b0;
    end

    // Write one to clear; a set arriving in the same cycle wins.
    flag_clr = (WR && ADDR == scp_pkg::ADDR_FLAGS) ? WDATA[4:0] : 5'h00;
    nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;

    // Safety output drive; faults stay latched through the flags.
    if (active_mode) begin
      nxt_st.safety_drive = nxt_st.safe_state;
    end else begin
      nxt_st.safety_drive = (|nxt_st.flags[4:1]) && !EVT.input_undervoltage_detect;
    end

    // Configuration strap effects.
    nxt_st.bus_addr = strap_s ? scp_pkg::CFG_MODE_BUS_ADDR : FUSED_BUS_ADDR;

    // Fail-sync sequencing.
    case (st_ff.fs)
      scp_pkg::FS_OFF: begin
        nxt_st.fail_drive = fs_en;
        nxt_st.cnt        = '0;
        nxt_st.deb        = '0;
        if (SYS.power_on_request && SYS.ready_to_sequence) begin
          nxt_st.fs         = scp_pkg::FS_RELEASED;
          nxt_st.fail_drive = 1'b0;
        end
      end
      scp_pkg::FS_RELEASED: begin
        nxt_st.fail_drive = 1'b0;
        if (fs_en && SYS.system_on && !fail_pin_s) begin
          nxt_st.deb = st_ff.deb + scp_cnt_t'(1);
        end else begin
          nxt_st.deb = '0;
        end
        if (SYS.off_mode) begin
          nxt_st.fs = scp_pkg::FS_OFF;
        end else if (hard_shutdown || EVT.hard_wdog_reset) begin
          nxt_st.wdog_down  = EVT.hard_wdog_reset;
          nxt_st.fail_drive = fs_en;
          nxt_st.cnt        = '0;
          nxt_st.fs         = scp_pkg::FS_PRE_DOWN;
        end else if (st_ff.deb == scp_cnt_t'(scp_pkg::DEBOUNCE_CYC - 1)) begin
          nxt_st.fail_drive = 1'b1;
          nxt_st.down_start = 1'b1;
          nxt_st.wdog_down  = 1'b0;
          nxt_st.fs         = scp_pkg::FS_DOWN;
        end
      end
      scp_pkg::FS_PRE_DOWN: begin
        // Without the fused enable the pin stays untouched and power down is not delayed.
        nxt_st.cnt = st_ff.cnt + scp_cnt_t'(1);
        if (!fs_en || st_ff.cnt == scp_cnt_t'(scp_pkg::SYNC_LEAD_CYC - 1)) begin
          nxt_st.down_start = 1'b1;
          nxt_st.fs         = scp_pkg::FS_DOWN;
        end
      end
      scp_pkg::FS_DOWN: begin
        nxt_st.cnt = '0;
        if (SYS.outputs_off) begin
          nxt_st.fs = st_ff.wdog_down ? scp_pkg::FS_WDOG_HOLD : scp_pkg::FS_OFF;
        end
      end
      scp_pkg::FS_WDOG_HOLD: begin
        nxt_st.cnt = st_ff.cnt + scp_cnt_t'(1);
        if (st_ff.cnt == scp_cnt_t'(scp_pkg::WDOG_REL_CYC - 1)) begin
          nxt_st.fail_drive  = 1'b0;
          nxt_st.fuse_reload = 1'b1;
          nxt_st.wdog_down   = 1'b0;
          nxt_st.deb         = '0;
          nxt_st.fs          = scp_pkg::FS_RELEASED;
        end
      end
      default: begin
        nxt_st.fs = scp_pkg::FS_OFF;
      end
    endcase
    if (!fs_en) begin
      nxt_st.fail_drive = 1'b0;
    end

    // Register reads, answered one cycle later.
    if (RD) begin
      if (ADDR == scp_pkg::ADDR_CTRL) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (ADDR == scp_pkg::ADDR_FLAGS) begin
        nxt_st.rdata = {3'h0, st_ff.flags};
      end else if (ADDR == scp_pkg::ADDR_STATUS) begin
        nxt_st.rdata = {2'h0, active_mode, st_ff.safe_state, fail_pin_s,
                        st_ff.safety_drive, strap_s, en_pin_s};
      end else if (ADDR == scp_pkg::ADDR_BUSID) begin
        nxt_st.rdata = {1'b0, st_ff.bus_addr};
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_ff          <= '0;
      st_ff.ctrl     <= scp_pkg::CTRL_RST;
      st_ff.flags    <= scp_pkg::FLAGS_RST;
      st_ff.fs       <= scp_pkg::FS_OFF;
      st_ff.bus_addr <= scp_pkg::CFG_MODE_BUS_ADDR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign RDATA                = st_ff.rdata;
  assign REGULATOR_TWO_ENABLE = st_ff.reg2_enable;
  assign SAFETY_OUT_N_O       = 1'b0;
  assign SAFETY_OUT_N_OE      = st_ff.safety_drive;
  assign SYNC_FAIL_N_O        = 1'b0;
  assign SYNC_FAIL_N_OE       = st_ff.fail_drive;
  assign BUS_ADDR             = st_ff.bus_addr;
  assign WDOG_DISABLE         = strap_s;
  assign CRC_SECURE_DISABLE   = strap_s && !SYS.power_up_event;
  // Power up waits while a peer still holds the shared line low.
  assign POWER_UP_PAUSE       = fs_en && !SYS.system_on && st_ff.fs == scp_pkg::FS_RELEASED
                              && !fail_pin_s;
  assign POWER_DOWN_START     = st_ff.down_start;
  assign FUSE_RELOAD          = st_ff.fuse_reload;

endmodule : scp_pin_ctrl

/* test/scp_peer.sv */
// Peer power device sharing the open-drain fail-sync wire.
`timescale 1ns/100ps
module scp_peer (
  input  wire logic dut_oe,
  input  wire logic dut_o,
  input  wire logic pull,
  output logic      pin
);
  // ****************************************************************
  // Wired-AND with pull-up
  // ****************************************************************
  // A released wire floats to the pull-up level, never to a stale value.
  assign pin = (dut_oe ? dut_o : 1'b1) & ~pull;
endmodule : scp_peer

/* test/scp_pin_ctrl_properties.sv */
// Port-level checks for the safety and pin control block.
`timescale 1ns/100ps
module scp_pin_ctrl_properties (
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire scp_pkg::scp_sys_s SYS,
  input wire scp_pkg::scp_evt_s EVT,
  input wire logic              HOST_RESET_N,
  input wire logic              FUSED_ACTIVE_SAFE_ENABLE,
  input wire logic              FUSED_SYNC_FAIL_ENABLE,
  input wire logic              CONFIG_MODE_STRAP,
  input wire logic              SYNC_FAIL_N_I,
  input wire logic              SYNC_FAIL_N_OE,
  input wire logic              SAFETY_OUT_N_OE,
  input wire logic              REGULATOR_TWO_ENABLE,
  input wire logic [6:0]        BUS_ADDR,
  input wire logic              WDOG_DISABLE,
  input wire logic              CRC_SECURE_DISABLE,
  input wire logic              POWER_DOWN_START
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  localparam int LEAD = scp_pkg::SYNC_LEAD_CYC;
  // Saturating count of cycles the shared wire has been low; one cycle of slack covers sampling.
  logic [11:0] low_cnt_ff;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_cnt_ff <= 12'h000;
    end else if (SYNC_FAIL_N_I) begin
      low_cnt_ff <= 12'h000;
    end else if (low_cnt_ff != 12'hFFF) begin
      low_cnt_ff <= low_cnt_ff + 12'h001;
    end
  end
  sequence s_strap_high; CONFIG_MODE_STRAP [*4]; endsequence
  sequence s_off_held; (FUSED_SYNC_FAIL_ENABLE && SYS.off_mode) [*3]; endsequence
  property p_strap_addr; s_strap_high |=> BUS_ADDR == 7'h08; endproperty
  property p_wdog_dis; s_strap_high |=> WDOG_DISABLE; endproperty
  property p_crc; s_strap_high ##1 1'b1 |-> CRC_SECURE_DISABLE == !SYS.power_up_event; endproperty
  property p_no_fuse; !FUSED_SYNC_FAIL_ENABLE [*2] |-> !SYNC_FAIL_N_OE; endproperty
  property p_off_drive; s_off_held |-> SYNC_FAIL_N_OE; endproperty
  property p_fail_lead;
    FUSED_SYNC_FAIL_ENABLE && POWER_DOWN_START |-> SYNC_FAIL_N_OE && low_cnt_ff >= LEAD - 1;
  endproperty
  property p_reg_term; REGULATOR_TWO_ENABLE |-> $past(SYS.run_state || SYS.standby_state); endproperty
  property p_ass_load; FUSED_ACTIVE_SAFE_ENABLE && SYS.fuses_loaded |=> SAFETY_OUT_N_OE; endproperty
  property p_ass_entry;
    FUSED_ACTIVE_SAFE_ENABLE && (EVT.self_test_fail || EVT.hard_wdog_reset || SYS.off_mode && !HOST_RESET_N)
      |=> SAFETY_OUT_N_OE;
  endproperty
  property p_ass_exit;
    FUSED_ACTIVE_SAFE_ENABLE && $fell(SAFETY_OUT_N_OE)
      |-> $past(HOST_RESET_N && !EVT.self_test_fail && !EVT.regulator_fault);
  endproperty
  property p_uv_release; !FUSED_ACTIVE_SAFE_ENABLE && EVT.input_undervoltage_detect |=> !SAFETY_OUT_N_OE; endproperty
  a_strap_addr: assert property (p_strap_addr) else $error("bus address not fixed");
  a_wdog_dis: assert property (p_wdog_dis) else $error("watchdog not disabled");
  a_crc: assert property (p_crc) else $error("crc disable wrong");
  a_no_fuse: assert property (p_no_fuse) else $error("fail-sync driven while fused off");
  a_off_drive: assert property (p_off_drive) else $error("fail-sync released in off mode");
  a_fail_lead: assert property (p_fail_lead) else $error("power down without fail-sync lead");
  a_reg_term: assert property (p_reg_term) else $error("regulator on outside run or standby");
  a_ass_load: assert property (p_ass_load) else $error("safety output not asserted at fuse load");
  a_ass_entry: assert property (p_ass_entry) else $error("safe state not entered");
  a_ass_exit: assert property (p_ass_exit) else $error("safe state left too early");
  a_uv_release: assert property (p_uv_release) else $error("safety output held under undervoltage");
endmodule : scp_pin_ctrl_properties
bind scp_pin_ctrl scp_pin_ctrl_properties scp_pin_ctrl_properties_inst (.CLK, .SYS_RST, .SYS, .EVT, .HOST_RESET_N,
  .FUSED_ACTIVE_SAFE_ENABLE, .FUSED_SYNC_FAIL_ENABLE, .CONFIG_MODE_STRAP, .SYNC_FAIL_N_I, .SYNC_FAIL_N_OE,
  .SAFETY_OUT_N_OE, .REGULATOR_TWO_ENABLE, .BUS_ADDR, .WDOG_DISABLE, .CRC_SECURE_DISABLE, .POWER_DOWN_START);

/* test/scp_pin_ctrl_tb.sv */
// Self-checking bench for the safety and pin control block.
`timescale 1ns/100ps
module scp_pin_ctrl_tb;
  logic              clk, rst, wr, rd, host_n, f_ass, f_sf, en_pin, strap, pull;
  logic              sf_i, sf_oe, so_oe, reg_en, wdog_dis, pdown, reload, pause, so_o, sf_o, crc_dis;
  logic [3:0]        addr;
  logic [7:0]        wdata, rdata;
  logic [6:0]        bus_addr;
  scp_pkg::scp_sys_s sys;
  scp_pkg::scp_evt_s evt;
  int                n_fail = 0;
  int                n_tests = 0;
  int                n;
  // Event bit, select bit and flag bit of each fault kind.
  int ev[9] = '{10, 9, 8, 7, 5, 4, 3, 2, 1};
  int sl[9] = '{3, 4, 4, 5, 6, 6, 6, 6, 6};
  int fl[9] = '{2, 1, 1, 3, 4, 4, 4, 4, 4};
  scp_pin_ctrl scp_pin_ctrl_inst (
    .CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SYS(sys), .EVT(evt), .HOST_RESET_N(host_n), .FUSED_ACTIVE_SAFE_ENABLE(f_ass),
    .FUSED_SYNC_FAIL_ENABLE(f_sf), .FUSED_PIN_CONTROL_DEFAULT(1'b1), .FUSED_BUS_ADDR(7'h0B),
    .REGULATOR_TWO_ENABLE_PIN(en_pin), .CONFIG_MODE_STRAP(strap), .SYNC_FAIL_N_I(sf_i),
    .SYNC_FAIL_N_O(sf_o), .SYNC_FAIL_N_OE(sf_oe), .SAFETY_OUT_N_O(so_o), .SAFETY_OUT_N_OE(so_oe),
    .REGULATOR_TWO_ENABLE(reg_en), .BUS_ADDR(bus_addr), .WDOG_DISABLE(wdog_dis),
    .CRC_SECURE_DISABLE(crc_dis), .POWER_UP_PAUSE(pause), .POWER_DOWN_START(pdown), .FUSE_RELOAD(reload));
  scp_peer scp_peer_inst (.dut_oe(sf_oe), .dut_o(sf_o), .pull(pull), .pin(sf_i));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e & m);
  endtask : rd_reg
  // Counts edges until the chosen pulse shows; the limit keeps a missing pulse from hanging.
  task automatic wcnt(input bit which, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (c < lim && !(which ? reload : pdown));
  endtask : wcnt
  task automatic win(input int v, input int lo);
    chk(12'(v >= lo && v <= lo + 6), 12'h001);
  endtask : win
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #320000;
    n_fail++;
    stop_test();
  end
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    {wr, rd, host_n, f_ass, f_sf, en_pin, strap, pull} = 8'h00;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 8'h00;
    sys = '0;
    evt = '0;
    cyc(8);
    rst <= 1'b0;
    rd_reg(scp_pkg::ADDR_CTRL, scp_pkg::CTRL_RST, 8'hFF);
    rd_reg(scp_pkg::ADDR_FLAGS, 8'(scp_pkg::FLAGS_RST), 8'hFF);
    rd_reg(scp_pkg::ADDR_BUSID, 8'h0B, 8'hFF);
    rd_reg(4'h7, 8'h00, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      en_pin <= i[2];
      sys <= scp_pkg::scp_sys_s'(9'h100);
      wr_reg(scp_pkg::ADDR_CTRL, {6'h00, i[1], i[0]});
      cyc(4);
      #1 chk(reg_en, i[1] & (~i[0] | i[2]));
      rd_reg(scp_pkg::ADDR_STATUS, 8'(i[2]), 8'h01);
    end
    cyc(1);
    sys <= scp_pkg::scp_sys_s'(9'h080);
    wr_reg(scp_pkg::ADDR_CTRL, 8'h02);
    cyc(3);
    #1 chk(reg_en, 1'b0);
    wr_reg(scp_pkg::ADDR_CTRL, 8'h04);
    cyc(3);
    #1 chk(reg_en, 1'b1);
    wr_reg(scp_pkg::ADDR_CTRL, 8'hFF);
    rd_reg(scp_pkg::ADDR_CTRL, 8'h7F, 8'hFF);
    cyc(1);
    strap <= 1'b1;
    cyc(5);
    #1 chk(bus_addr, 7'h08);
    chk(wdog_dis, 1'b1);
    chk(crc_dis, 1'b1);
    rd_reg(scp_pkg::ADDR_BUSID, 8'h08, 8'hFF);
    cyc(1);
    strap <= 1'b0;
    sys <= scp_pkg::scp_sys_s'(9'h081);
    #1 chk(crc_dis, 1'b0);
    cyc(5);
    #1 chk(bus_addr, 7'h0B);
    for (int k = 0; k < 9; k++) begin
      for (int s = 0; s < 2; s++) begin
        wr_reg(scp_pkg::ADDR_CTRL, 8'(s << sl[k]));
        evt <= scp_pkg::scp_evt_s'(13'h0001 << ev[k]);
        cyc(1);
        evt <= '0;
        cyc(3);
        #1 chk(so_oe, 12'(s));
        rd_reg(scp_pkg::ADDR_FLAGS, 8'(s << fl[k]), 8'hFF);
        wr_reg(scp_pkg::ADDR_FLAGS, 8'h1F);
        cyc(2);
        #1 chk(so_oe, 1'b0);
      end
    end
    wr_reg(scp_pkg::ADDR_CTRL, 8'h08);
    evt <= scp_pkg::scp_evt_s'(13'h0400);
    cyc(1);
    evt <= scp_pkg::scp_evt_s'(13'h0001);
    cyc(3);
    #1 chk(so_oe, 1'b0);
    rd_reg(scp_pkg::ADDR_FLAGS, 8'h04, 8'hFF);
    cyc(1);
    evt <= '0;
    wr_reg(scp_pkg::ADDR_FLAGS, 8'h1F);
    cyc(1);
    f_ass <= 1'b1;
    sys <= scp_pkg::scp_sys_s'(9'h082);
    cyc(1);
    sys <= scp_pkg::scp_sys_s'(9'h080);
    cyc(2);
    #1 chk(so_oe, 1'b1);
    chk(so_o, 1'b0);
    rd_reg(scp_pkg::ADDR_CTRL, 8'h09, 8'hFF);
    rd_reg(scp_pkg::ADDR_FLAGS, 8'h01, 8'h01);
    cyc(1);
    host_n <= 1'b1;
    evt <= scp_pkg::scp_evt_s'(13'h0800);
    wr_reg(scp_pkg::ADDR_FLAGS, 8'h01);
    cyc(3);
    #1 chk(so_oe, 1'b1);
    cyc(1);
    evt <= '0;
    cyc(3);
    #1 chk(so_oe, 1'b0);
    for (int e = 0; e < 2; e++) begin
      cyc(1);
      evt <= scp_pkg::scp_evt_s'(e ? 13'h0040 : 13'h1000);
      cyc(1);
      evt <= '0;
      cyc(2);
      #1 chk(so_oe, 1'b1);
      rd_reg(scp_pkg::ADDR_FLAGS, 8'h01, 8'h01);
      wr_reg(scp_pkg::ADDR_FLAGS, 8'h01);
      cyc(3);
      #1 chk(so_oe, 1'b0);
    end
    cyc(1);
    host_n <= 1'b0;
    sys <= scp_pkg::scp_sys_s'(9'h040);
    cyc(2);
    #1 chk(so_oe, 1'b1);
    cyc(1);
    rst <= 1'b1;
    f_sf <= 1'b1;
    f_ass <= 1'b0;
    sys <= scp_pkg::scp_sys_s'(9'h040);
    cyc(8);
    rst <= 1'b0;
    cyc(3);
    #1 chk(sf_oe, 1'b1);
    cyc(1);
    sys <= scp_pkg::scp_sys_s'(9'h018);
    cyc(3);
    #1 chk(sf_oe, 1'b0);
    cyc(1);
    pull <= 1'b1;
    cyc(4);
    #1 chk(pause, 1'b1);
    cyc(1);
    pull <= 1'b0;
    cyc(4);
    #1 chk(pause, 1'b0);
    cyc(1);
    sys <= scp_pkg::scp_sys_s'(9'h020);
    pull <= 1'b1;
    wcnt(1'b0, 3000, n);
    win(n, scp_pkg::DEBOUNCE_CYC);
    chk(sf_oe, 1'b1);
    for (int h = 0; h < 2; h++) begin
      cyc(1);
      pull <= 1'b0;
      sys <= scp_pkg::scp_sys_s'(9'h004);
      cyc(3);
      #1 chk(sf_oe, 1'b1);
      cyc(1);
      sys <= scp_pkg::scp_sys_s'(9'h018);
      cyc(3);
      sys <= scp_pkg::scp_sys_s'(9'h020);
      evt <= scp_pkg::scp_evt_s'(h ? 13'h0040 : 13'h0002);
      cyc(1);
      evt <= '0;
      #1 chk(sf_oe, 1'b1);
      wcnt(1'b0, 3000, n);
      win(n, scp_pkg::SYNC_LEAD_CYC - 2);
    end
    cyc(1);
    sys <= scp_pkg::scp_sys_s'(9'h004);
    pull <= 1'b1;
    wcnt(1'b1, 5000, n);
    win(n, scp_pkg::WDOG_REL_CYC - 2);
    cyc(2);
    #1 chk(pause, 1'b1);
    cyc(1);
    pull <= 1'b0;
    cyc(4);
    #1 chk(pause, 1'b0);
    stop_test();
  end
endmodule : scp_pin_ctrl_tb
